// ===== rtl/nfc_pkg.sv
// package for the nand feature/protection host controller
// assumes one 50 MHz clock domain, avalon-mm register access
package nfc_pkg;
   // ------------------------------------------------------------
   // opcodes and feature addresses
   // ------------------------------------------------------------
   localparam logic [7:0] OP_SET_FEATURE  = 8'hEF;
   localparam logic [7:0] OP_GET_FEATURE  = 8'hEE;
   localparam logic [7:0] OP_STATUS       = 8'h70;
   localparam logic [7:0] OP_READ         = 8'h00;
   localparam logic [7:0] FA_ARRAY_MODE   = 8'h90;
   localparam logic [7:0] FA_BLOCK_PROT   = 8'hA0;
   localparam logic [7:0] MODE_NORMAL     = 8'h00;
   localparam logic [7:0] MODE_OTP        = 8'h01;
   localparam logic [7:0] MODE_OTP_PROT   = 8'h03;
   localparam logic [7:0] STATUS_PROT_ERR = 8'h60;
   localparam logic [7:0] BP_DEFAULT      = 8'h38;
   localparam logic [7:0] UPPER_ZERO      = 8'h00;
   // ------------------------------------------------------------
   // block-protection parameter byte layout
   // ------------------------------------------------------------
   localparam int BP_RANGE_LSB = 3;
   localparam int BP_INVERT    = 2;
   localparam int BP_COMPL     = 1;
   localparam int BP_SOLID     = 0;
   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_PARAM  = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_RESULT = 4'hC;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
   // ------------------------------------------------------------
   // timing: one bus phase per strobe
   // ------------------------------------------------------------
   localparam int CLK_MHZ       = 50;
   localparam int T_STROBE_NS   = 40;
   localparam int STROBE_CYCLES = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYCLES - 1);
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_CMD  = 3'b001,
      ST_ADDR = 3'b011,
      ST_DATA = 3'b010,
      ST_WAIT = 3'b110,
      ST_READ = 3'b111,
      ST_STAT = 3'b101
   } nfc_state_e;
   typedef struct packed
   {
      logic        cle;
      logic        ale;
      logic        we_n;
      logic        re_n;
      logic        ce_n;
      logic        wp_n;
      logic [15:0] dq_out;
      logic        dq_oe;
   } nfc_pins_s;
endpackage

// ===== rtl/nfc_host.sv
// host controller issuing set/get feature and status reads to a nand
// assumes asynchronous latch bus pins; ready/busy and dq inputs async
//
// Functional notes
// - set feature: opcode, one address byte, four parameter bytes
// - host drives zero on upper data byte for x16 feature bytes
// - get feature: opcode, address, then four parameter bytes read
// - after status poll in get feature, issue read opcode first (host polls the ready pin instead and never sends a read opcode)
// - otp entry: array-mode address, params 01h then zeros
// - otp program may use random input; max eight partials per page
// - otp protect: params 03h then zeros, program address zero
// - unprotect: write-protect high, then set feature block address
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
module nfc_host
   import nfc_pkg::*;
#(
   parameter int WIDE = 1
)
(
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   // avalon-mm slave
   input  wire logic [3:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   output logic [31:0]      o_readdata,
   output logic             o_waitrequest,
   // nand pins
   output nfc_pins_s        o_pins,
   input  wire logic [15:0] i_dq,
   input  wire logic        i_ready
);
   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   // ctrl: [7:0] feature address, [8] get(1)/set(0), [9] go,
   //       [10] status poll only, [11] write-protect release
   logic [31:0]     ctrl;
   logic [31:0]     params;
   logic [31:0]     result;
   logic [7:0]      status_byte;
   logic            busy;
   logic            done;
   nfc_state_e      state;
   logic [3:0]      tick;
   logic [2:0]      idx;
   logic            phase;
   logic [2:0]      rdy_sync;
   logic            rdy;
   logic [15:0]     dq_a;
   logic [15:0]     dq_b;
   logic            rvalid;
   wire logic       go_wr = i_write && i_address == REG_CTRL
                            && i_writedata[9] && !busy;

   // one wait state on reads so readdata is settled when accepted
   assign o_waitrequest = i_read && !rvalid;

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         ctrl   <= CTRL_RESET;
         params <= PARAM_RESET;
      end
      else if (i_write && !busy)
      begin
         if (i_address == REG_CTRL)
            ctrl <= i_writedata;
         else if (i_address == REG_PARAM)
            params <= i_writedata;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_readdata <= 32'h0000_0000;
         rvalid     <= 1'b0;
      end
      else
      begin
         rvalid <= i_read && !rvalid;
         if (i_read && !rvalid)
         begin
            case (i_address)
               REG_CTRL:   o_readdata <= ctrl;
               REG_PARAM:  o_readdata <= params;
               REG_STATUS: o_readdata <= {21'h0, rdy, busy, done,
                                          status_byte};
               REG_RESULT: o_readdata <= result;
               default:    o_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // ready/busy and dq synchronisers
   // ------------------------------------------------------------
   // change counts once stages two and three agree
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         rdy_sync <= 3'h0;
         rdy      <= 1'b0;
         dq_a     <= 16'h0000;
         dq_b     <= 16'h0000;
      end
      else
      begin
         rdy_sync <= {rdy_sync[1:0], i_ready};
         if (rdy_sync[2] == rdy_sync[1])
            rdy <= rdy_sync[2];
         dq_a <= i_dq;
         dq_b <= dq_a;
      end
   end

   // ------------------------------------------------------------
   // bus sequencer
   // ------------------------------------------------------------
   // each byte is two phases: strobe low, strobe high
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         state       <= ST_IDLE;
         tick        <= 4'h0;
         idx         <= 3'h0;
         phase       <= 1'b0;
         busy        <= 1'b0;
         done        <= 1'b0;
         result      <= 32'h0000_0000;
         status_byte <= 8'h00;
      end
      else if (state == ST_IDLE)
      begin
         tick  <= 4'h0;
         phase <= 1'b0;
         idx   <= 3'h0;
         if (go_wr)
         begin
            busy  <= 1'b1;
            done  <= 1'b0;
            state <= i_writedata[10] ? ST_STAT : ST_CMD;
         end
      end
      else if (tick != STROBE_LAST)
         tick <= tick + 4'h1;
      else
      begin
         tick  <= 4'h0;
         phase <= ~phase;
         if (phase)
         begin
            case (state)
               ST_CMD:  state <= ST_ADDR;
               ST_ADDR: state <= ctrl[8] ? ST_WAIT : ST_DATA;
               ST_DATA:
                  if (idx == 3'h3)
                     state <= ST_WAIT;
                  else
                     idx <= idx + 3'h1;
               // ready pin polled, not status: no read opcode to resume
               ST_WAIT:
                  if (rdy)
                  begin
                     idx   <= 3'h0;
                     state <= ctrl[8] ? ST_READ : ST_IDLE;
                     busy  <= ctrl[8];
                     done  <= !ctrl[8];
                  end
               ST_READ:
               begin
                  result[idx[1:0]*8 +: 8] <= dq_b[7:0];
                  if (idx == 3'h3)
                  begin
                     state <= ST_IDLE;
                     busy  <= 1'b0;
                     done  <= 1'b1;
                  end
                  else
                     idx <= idx + 3'h1;
               end
               ST_STAT:
                  if (idx == 3'h0)
                     idx <= 3'h1;
                  else
                  begin
                     // status byte: 60h flags protected reject
                     status_byte <= dq_b[7:0];
                     state       <= ST_IDLE;
                     busy        <= 1'b0;
                     done        <= 1'b1;
                  end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_pins.cle    <= 1'b0;
         o_pins.ale    <= 1'b0;
         o_pins.we_n   <= 1'b1;
         o_pins.re_n   <= 1'b1;
         o_pins.ce_n   <= 1'b1;
         o_pins.wp_n   <= 1'b0;
         o_pins.dq_out <= 16'h0000;
         o_pins.dq_oe  <= 1'b0;
      end
      else
      begin
         o_pins.wp_n <= ctrl[11];
         o_pins.ce_n <= (state == ST_IDLE);
         o_pins.cle  <= (state == ST_CMD)
                        || (state == ST_STAT && idx == 3'h0);
         o_pins.ale  <= (state == ST_ADDR);
         o_pins.we_n <= !(!phase && (state == ST_CMD || state == ST_ADDR
                        || state == ST_DATA
                        || (state == ST_STAT && idx == 3'h0)));
         o_pins.re_n <= !(!phase && (state == ST_READ
                        || (state == ST_STAT && idx != 3'h0)));
         o_pins.dq_oe <= (state == ST_CMD || state == ST_ADDR
                          || state == ST_DATA
                          || (state == ST_STAT && idx == 3'h0));
         case (state)
            ST_CMD:  o_pins.dq_out <= {UPPER_ZERO, ctrl[8] ?
                                       OP_GET_FEATURE : OP_SET_FEATURE};
            ST_ADDR: o_pins.dq_out <= {UPPER_ZERO, ctrl[7:0]};
            ST_DATA: o_pins.dq_out <= {UPPER_ZERO,
                                       params[idx[1:0]*8 +: 8]};
            ST_STAT: o_pins.dq_out <= {UPPER_ZERO, OP_STATUS};
            default: o_pins.dq_out <= 16'h0000;
         endcase
      end
   end
endmodule

// ===== tb/nfc_host_monitor.sv
// concurrent checks on the nand pins and avalon wait of nfc_host
// assumes binding into nfc_host; sees only its ports
`timescale 1ns/10ps
module nfc_host_monitor
   import nfc_pkg::*;
(
   input wire logic      i_clock,
   input wire logic      i_rst,
   input wire logic      i_read,
   input wire logic      o_waitrequest,
   input wire nfc_pins_s o_pins
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // ------------------------------------------------------------
   // pin protocol and avalon wait
   // ------------------------------------------------------------
   chk_reset_idle: assert property (disable iff (1'b0) i_rst |=>
      o_pins.ce_n && o_pins.we_n && o_pins.re_n && !o_pins.dq_oe)
      else $error("pins not idle after reset");
   chk_wait_read: assert property (o_waitrequest |-> i_read)
      else $error("waitrequest raised without a read");
   chk_wait_short: assert property (o_waitrequest |=> !o_waitrequest)
      else $error("read stalled longer than one cycle");
   chk_we_width: assert property
      ($fell(o_pins.we_n) |=> !o_pins.we_n ##1 o_pins.we_n)
      else $error("write strobe low time wrong");
   chk_re_width: assert property
      ($fell(o_pins.re_n) |=> !o_pins.re_n ##1 o_pins.re_n)
      else $error("read strobe low time wrong");
   chk_upper_zero: assert property
      (o_pins.dq_oe |-> o_pins.dq_out[15:8] == UPPER_ZERO)
      else $error("upper data byte not zero");
   chk_latch_excl: assert property (!(o_pins.cle && o_pins.ale))
      else $error("command and address latch together");
   chk_strobe_excl: assert property
      (!(!o_pins.we_n && !o_pins.re_n))
      else $error("both strobes low");
   chk_ce_frame: assert property
      ((!o_pins.we_n || !o_pins.re_n) |-> !o_pins.ce_n)
      else $error("strobe without chip enable");
   chk_read_release: assert property (!o_pins.re_n |-> !o_pins.dq_oe)
      else $error("host drives data during read");
endmodule
bind nfc_host nfc_host_monitor u_mon
(
   .i_clock       (i_clock),
   .i_rst         (i_rst),
   .i_read        (i_read),
   .o_waitrequest (o_waitrequest),
   .o_pins        (o_pins)
);

// ===== tb/nfc_dev_model.sv
// behavioural nand: feature registers, status and ready/busy
// assumes x16 pins from nfc_host; i_dq is the resolved wire
`timescale 1ns/10ps
module nfc_dev_model
   import nfc_pkg::*;
#(
   parameter int T_BUSY_NS = 300,
   parameter int T_HOLD_NS = 60
)
(
   // strap and pins
   input  wire logic      i_strap,
   input  wire nfc_pins_s i_pins,
   input  wire logic [15:0] i_dq,
   // device outputs
   output logic [15:0]    o_dq,
   output logic           o_ready
);
   logic [7:0]  cmd;
   logic [7:0]  fa;
   logic [7:0]  p1;
   logic        wp_cmd = 1'b0;
   logic [7:0]  mode = MODE_NORMAL;
   logic [7:0]  bp = BP_DEFAULT;
   int          n = 0;
   int          rid = 0;
   int          hid;
   initial o_dq = 16'h5A5A;
   initial o_ready = 1'b1;
   task automatic busy();
      o_ready = 1'b0;
      #(T_BUSY_NS);
      o_ready = 1'b1;
   endtask
   // any latched opcode only replaces cmd, n and wp_cmd; stored features untouched
   always @(posedge i_pins.we_n)
   begin
      if (i_pins.cle)
      begin
         cmd = i_dq[7:0];
         n = 0;
         wp_cmd = i_pins.wp_n;
      end
      else if (i_pins.ale)
      begin
         fa = i_dq[7:0];
         if (cmd == OP_GET_FEATURE) fork busy(); join_none
      end
      else if (cmd == OP_SET_FEATURE)
      begin
         if (n == 0) p1 = i_dq[7:0];
         n++;
         if (n == 4)
         begin
            if (fa == FA_ARRAY_MODE) mode = p1;
            if (fa == FA_BLOCK_PROT && i_strap && wp_cmd
                && !bp[BP_SOLID])
               bp = p1;
            fork busy(); join_none
         end
      end
   end
   // upper byte toggles: it carries nothing defined
   always @(negedge i_pins.re_n)
   begin
      rid++;
      if (cmd == OP_STATUS)
         o_dq = {~o_dq[15:8], o_ready ? 8'hE0 : 8'hA0};
      else
         o_dq = {~o_dq[15:8], n != 0 ? 8'h00 : fa == FA_BLOCK_PROT ?
                 bp : fa == FA_ARRAY_MODE ? mode : 8'h00};
      n++;
   end
   always @(posedge i_pins.re_n)
   begin
      hid = rid;
      #(T_HOLD_NS);
      if (i_pins.re_n && hid == rid) o_dq = ~o_dq;
   end
endmodule

// ===== tb/nfc_host_tb.sv
// self-checking bench for nfc_host with a behavioural nand model
// assumes the model answers p2..p4 of every feature as zero
`timescale 1ns/10ps
module nfc_host_tb
   import nfc_pkg::*;
;
   logic        i_clock = 1'b0;
   logic        i_rst = 1'b1;
   logic [3:0]  i_address = 4'h0;
   logic        i_read = 1'b0;
   logic        i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0;
   logic [31:0] o_readdata;
   logic        o_waitrequest;
   nfc_pins_s   o_pins;
   logic [15:0] dev_dq;
   logic [15:0] pin_dq;
   logic        ready;
   logic        strap = 1'b1;
   logic [31:0] seen;
   logic [31:0] exp_q[$];
   string       name_q[$];
   int          fail_count = 0;
   int          cmp_count = 0;
   event        got;
   assign pin_dq = o_pins.dq_oe ? o_pins.dq_out : dev_dq;
   always #10 i_clock = ~i_clock;
   nfc_host dut (.i_clock(i_clock), .i_rst(i_rst), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .o_pins(o_pins), .i_dq(pin_dq), .i_ready(ready));
   nfc_dev_model u_dev (.i_strap(strap), .i_pins(o_pins), .i_dq(pin_dq),
      .o_dq(dev_dq), .o_ready(ready));
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e)
      begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   always @(got) check(name_q.pop_front(), seen, exp_q.pop_front());
   task automatic limit(input int k, m);
      if (k >= m)
      begin
         fail_count++;
         close_out();
      end
   endtask
   // read data is taken at the edge that samples waitrequest low
   task automatic bus(input logic [3:0] a, input logic rd,
                      input logic [31:0] d, output logic [31:0] q);
      int k;
      i_address <= a;
      i_writedata <= d;
      i_read <= rd;
      i_write <= !rd;
      k = 0;
      do @(posedge i_clock); while (o_waitrequest !== 1'b0 && ++k < 64);
      q = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
      @(posedge i_clock);
      limit(k, 64);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, string nm);
      exp_q.push_back(e);
      name_q.push_back(nm);
      bus(a, 1'b1, 32'h0, seen);
      -> got;
   endtask
   task automatic run(input logic [31:0] c);
      logic [31:0] s;
      int k;
      bus(REG_CTRL, 1'b0, c, s);
      k = 0;
      do bus(REG_STATUS, 1'b1, 32'h0, s); while (s[9:8] !== 2'b01 && ++k < 200);
      limit(k, 200);
   endtask
   task automatic fset(input logic [7:0] fa, p);
      logic [31:0] s;
      bus(REG_PARAM, 1'b0, {24'h0, p}, s);
      run({20'h0, 1'b1, 3'b010, fa});
   endtask
   task automatic fget(input logic [7:0] fa, e, input string nm);
      run({20'h0, 1'b1, 3'b011, fa});
      rd(REG_RESULT, {24'h0, e}, nm);
   endtask
   initial
   begin
      logic [7:0]  b;
      logic [31:0] t;
      logic [7:0]  modes [3];
      modes = '{MODE_OTP, MODE_OTP_PROT, MODE_NORMAL};
      void'($urandom(99072));
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      rd(REG_CTRL, CTRL_RESET, "ctrl");
      rd(REG_PARAM, PARAM_RESET, "param");
      rd(4'h2, 32'h0, "unmapped");
      fget(FA_BLOCK_PROT, BP_DEFAULT, "bp power-on");
      fget(FA_ARRAY_MODE, MODE_NORMAL, "mode power-on");
      $display("test reset done");
      foreach (modes[i])
      begin
         fset(FA_ARRAY_MODE, modes[i]);
         fget(FA_ARRAY_MODE, modes[i], "mode");
      end
      t = $urandom;
      fset({1'b0, t[6:0]}, 8'hFF);
      fget(FA_ARRAY_MODE, MODE_NORMAL, "mode reserved");
      fget(FA_BLOCK_PROT, BP_DEFAULT, "bp reserved");
      $display("test array mode done");
      repeat (4)
      begin
         t = $urandom;
         b = {2'b00, t[5:1], 1'b0};
         fset(FA_BLOCK_PROT, b);
         fget(FA_BLOCK_PROT, b, "bp range");
      end
      strap <= 1'b0;
      fset(FA_BLOCK_PROT, b ^ 8'h38);
      fget(FA_BLOCK_PROT, b, "bp no strap");
      strap <= 1'b1;
      bus(REG_PARAM, 1'b0, {24'h0, b ^ 8'h38}, t);
      run({20'h0, 1'b0, 3'b010, FA_BLOCK_PROT});
      fget(FA_BLOCK_PROT, b, "bp wp low");
      fset(FA_BLOCK_PROT, b | 8'h01);
      fget(FA_BLOCK_PROT, b | 8'h01, "bp solid");
      fset(FA_BLOCK_PROT, BP_DEFAULT);
      fget(FA_BLOCK_PROT, b | 8'h01, "bp frozen");
      $display("test block protect done");
      run({20'h0, 1'b1, 3'b110, 8'h00});
      rd(REG_STATUS, 32'h0000_05E0, "status");
      $display("test status done");
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      rd(REG_STATUS, 32'h0, "status after reset");
      fget(FA_BLOCK_PROT, b | 8'h01, "bp after reset");
      $display("test reset rerun done");
      close_out();
   end
endmodule
